// [verilog/usbc_pkg.sv]
`default_nettype none
package usbc_pkg;
    // ---------------------------------------------------------------
    // Register indices (byte address is four times the index).
    // ---------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam logic [ADDR_W-1:0] IDX_GUARD   = 8'h00;
    localparam logic [ADDR_W-1:0] IDX_BASE1   = 8'h01;
    localparam logic [ADDR_W-1:0] IDX_BASE2   = 8'h02;
    localparam logic [ADDR_W-1:0] IDX_BASE3   = 8'h03;
    localparam logic [ADDR_W-1:0] IDX_CFG     = 8'h04;
    localparam logic [ADDR_W-1:0] IDX_PWR     = 8'h05;
    localparam logic [ADDR_W-1:0] IDX_STATUS  = 8'h06;
    localparam logic [ADDR_W-1:0] IDX_LIMIT   = 8'h07;

    // ---------------------------------------------------------------
    // Field layouts and reset values.
    // ---------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE      = 8'h00;
    localparam logic [7:0]  BASE1_MASK    = 8'hfe;
    localparam logic [7:0]  CFG_MASK      = 8'hd9;
    localparam int unsigned CFG_EYE       = 7;
    localparam int unsigned CFG_OEMON     = 6;
    localparam int unsigned CFG_HALT_IDLE = 4;
    localparam int unsigned CFG_LS_ONLY   = 3;
    localparam int unsigned CFG_AUTO_SUSP = 0;
    localparam int unsigned PWR_SUSPEND   = 1;
    localparam int unsigned BASE_ALIGN_W  = 9;
    localparam logic [8:0]  BASE_ALIGN_Z  = 9'h000;

    // ---------------------------------------------------------------
    // Frame timing: 1 ms frame, 12 Mb/s byte time.
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 40000000;
    localparam int unsigned FRAME_US        = 1000;
    localparam int unsigned FRAME_CYC       = CLK_HZ / 1000000 * FRAME_US;
    localparam int unsigned BYTE_NS         = 667;
    localparam int unsigned CLK_NS          = 25;
    localparam int unsigned BYTE_CYC        = BYTE_NS / CLK_NS;
    localparam logic [15:0] ZERO16          = 16'h0000;
    localparam logic [15:0] ONE16           = 16'h0001;
endpackage
`default_nettype wire

// [verilog/usbc_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module usbc_sync
    import usbc_pkg::*;
#(
    parameter int unsigned W = 2
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_b_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_ff <= '0;
            sync_o  <= '0;
        end else begin
            meta_ff <= async_i;
            sync_o  <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// [verilog/usbc_frame_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module usbc_frame_timer
    import usbc_pkg::*;
#(
    parameter int unsigned FRAME_CYCLES = FRAME_CYC
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        run_i,
    output logic             sof_o,
    output logic [15:0]      bytes_left_o
);
    // ---------------------------------------------------------------
    // Counts byte times left until the next frame start.
    // ---------------------------------------------------------------
    logic [15:0] cyc_ff;
    logic [15:0] sub_ff;
    localparam logic [15:0] FRAME_LAST = 16'(FRAME_CYCLES - 1);
    localparam logic [15:0] BYTE_LAST  = 16'(BYTE_CYC - 1);
    localparam logic [15:0] BYTES_PER  = 16'(FRAME_CYCLES / BYTE_CYC);

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cyc_ff       <= ZERO16;
            sub_ff       <= ZERO16;
            bytes_left_o <= ZERO16;
            sof_o        <= 1'b0;
        end else if (!run_i) begin
            sof_o <= 1'b0;
        end else begin
            sof_o <= (cyc_ff == FRAME_LAST);
            if (cyc_ff == FRAME_LAST) begin
                cyc_ff       <= ZERO16;
                sub_ff       <= ZERO16;
                bytes_left_o <= BYTES_PER;
            end else begin
                cyc_ff <= cyc_ff + ONE16;
                if (sub_ff == BYTE_LAST) begin
                    sub_ff <= ZERO16;
                    if (bytes_left_o != ZERO16) begin
                        bytes_left_o <= bytes_left_o - ONE16;
                    end
                end else begin
                    sub_ff <= sub_ff + ONE16;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [verilog/usbc_cfg_regs.sv]
// How it works
// - Frame guard threshold is an 8-bit read/write field, reset zero.
// - First base register holds base bits 7..1 of its byte; bit 0 reads zero.
// - Second base register holds an 8-bit writable base field.
// - Third base register holds the uppermost 8-bit base field.
// - Table base is 32 bits, 512-byte aligned; low nine bits assumed zero.
// - Bits 31..8 (31..16 in the limit register) and unimplemented bits ignore writes and read zero.
// - Configuration bit 7 enables the eye-pattern test.
// - Configuration bit 6 lets the output-enable monitor mark driven intervals.
// - Configuration bit 4 stops the module while the device is idle.
// - Configuration bit 3 selects low-speed-only device operation.
// - Configuration bit 0 suspends the module automatically on sleep.
`timescale 1ns/1ps
`default_nettype none
module usbc_cfg_regs
    import usbc_pkg::*;
#(
    parameter int unsigned FRAME_CYCLES = FRAME_CYC
) (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_b_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [31:0]       wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [31:0]       rdata_o,
    input  wire logic              idle_mode_i,
    input  wire logic              sleep_mode_i,
    input  wire logic              host_mode_i,
    input  wire logic              line_drive_i,
    input  wire logic              token_req_i,
    output logic                   token_go_o,
    output logic                   token_hold_o,
    output logic      [31:0]       table_base_o,
    output logic                   eye_pattern_test_en_o,
    output logic                   output_enable_monitor_o,
    output logic                   low_speed_only_device_o,
    output logic                   module_halted_o,
    output logic                   module_suspended_o,
    output logic                   usb_clk_en_o
);
    // ---------------------------------------------------------------
    // Register storage.
    // ---------------------------------------------------------------
    logic [7:0] frame_guard_threshold_ff;
    logic [7:0] table_base_low_field_ff;
    logic [7:0] table_base_high_field_ff;
    logic [7:0] table_base_upper_field_ff;
    logic [7:0] link_configuration_one_ff;
    logic [7:0] power_control_reg_ff;

    logic       idle_s;
    logic       sleep_s;
    logic       host_s;
    logic       drive_s;
    logic       sof;
    logic [15:0] bytes_left;
    logic       halted;
    logic       suspended;
    logic       guard_block;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] idx);
        hit = (a == idx);
    endfunction

    // ---------------------------------------------------------------
    // Pin inputs pass two flip-flops.
    // ---------------------------------------------------------------
    usbc_sync #(
        .W (4)
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .async_i   ({idle_mode_i, sleep_mode_i, host_mode_i, line_drive_i}),
        .sync_o    ({idle_s, sleep_s, host_s, drive_s})
    );

    // ---------------------------------------------------------------
    // Register writes.
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            frame_guard_threshold_ff <= RST_BYTE;
        end else if (wr_i && hit(addr_i, IDX_GUARD)) begin
            frame_guard_threshold_ff <= wdata_i[7:0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            table_base_low_field_ff   <= RST_BYTE;
            table_base_high_field_ff  <= RST_BYTE;
            table_base_upper_field_ff <= RST_BYTE;
        end else if (wr_i) begin
            if (hit(addr_i, IDX_BASE1)) begin
                table_base_low_field_ff <= wdata_i[7:0] & BASE1_MASK;
            end
            if (hit(addr_i, IDX_BASE2)) begin
                table_base_high_field_ff <= wdata_i[7:0];
            end
            if (hit(addr_i, IDX_BASE3)) begin
                table_base_upper_field_ff <= wdata_i[7:0];
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            link_configuration_one_ff <= RST_BYTE;
            power_control_reg_ff      <= RST_BYTE;
        end else if (wr_i) begin
            if (hit(addr_i, IDX_CFG)) begin
                link_configuration_one_ff <= wdata_i[7:0] & CFG_MASK;
            end
            if (hit(addr_i, IDX_PWR)) begin
                power_control_reg_ff <= {6'h00, wdata_i[PWR_SUSPEND], 1'b0};
            end
        end
    end

    // ---------------------------------------------------------------
    // Operating state.
    // ---------------------------------------------------------------
    assign halted    = link_configuration_one_ff[CFG_HALT_IDLE] & idle_s;
    assign suspended = power_control_reg_ff[PWR_SUSPEND]
                     | (link_configuration_one_ff[CFG_AUTO_SUSP] & sleep_s);

    usbc_frame_timer #(
        .FRAME_CYCLES (FRAME_CYCLES)
    ) u_timer (
        .sys_clk_i    (sys_clk_i),
        .rst_b_i      (rst_b_i),
        .run_i        (host_s & ~halted & ~suspended),
        .sof_o        (sof),
        .bytes_left_o (bytes_left)
    );

    // Tokens are held off near frame start so they cannot collide with it.
    assign guard_block = host_s & (bytes_left < {8'h00, frame_guard_threshold_ff});

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            token_go_o   <= 1'b0;
            token_hold_o <= 1'b0;
        end else begin
            token_hold_o <= guard_block | halted | suspended;
            token_go_o   <= token_req_i & ~guard_block & ~halted & ~suspended & ~sof;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            table_base_o <= 32'h00000000;
        end else begin
            table_base_o <= {table_base_upper_field_ff, table_base_high_field_ff,
                             table_base_low_field_ff[7:1], BASE_ALIGN_Z};
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            eye_pattern_test_en_o   <= 1'b0;
            output_enable_monitor_o <= 1'b0;
            low_speed_only_device_o <= 1'b0;
            module_halted_o         <= 1'b0;
            module_suspended_o      <= 1'b0;
            usb_clk_en_o            <= 1'b0;
        end else begin
            eye_pattern_test_en_o   <= link_configuration_one_ff[CFG_EYE];
            output_enable_monitor_o <= link_configuration_one_ff[CFG_OEMON] & drive_s;
            low_speed_only_device_o <= link_configuration_one_ff[CFG_LS_ONLY];
            module_halted_o         <= halted;
            module_suspended_o      <= suspended;
            usb_clk_en_o            <= ~suspended;
        end
    end

    // ---------------------------------------------------------------
    // Register reads: data stand in the cycle after the strobe.
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 32'h00000000;
        end else if (rd_i) begin
            unique case (addr_i)
                IDX_GUARD:  rdata_o <= {24'h000000, frame_guard_threshold_ff};
                IDX_BASE1:  rdata_o <= {24'h000000, table_base_low_field_ff};
                IDX_BASE2:  rdata_o <= {24'h000000, table_base_high_field_ff};
                IDX_BASE3:  rdata_o <= {24'h000000, table_base_upper_field_ff};
                IDX_CFG:    rdata_o <= {24'h000000, link_configuration_one_ff};
                IDX_PWR:    rdata_o <= {24'h000000, power_control_reg_ff};
                IDX_STATUS: rdata_o <= {26'h0000000, host_s, sleep_s, idle_s, halted,
                                        suspended, guard_block};
                IDX_LIMIT:  rdata_o <= {16'h0000, bytes_left};
                default:    rdata_o <= 32'h00000000;
            endcase
        end else begin
            rdata_o <= 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// [test/usbc_cfg_regs_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module usbc_cfg_regs_monitor
    import usbc_pkg::*;
(
    input wire logic              sys_clk_i,
    input wire logic              rst_b_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [31:0]       wdata_i,
    input wire logic              wr_i,
    input wire logic              rd_i,
    input wire logic [31:0]       rdata_o,
    input wire logic              token_req_i,
    input wire logic              token_go_o,
    input wire logic [31:0]       table_base_o,
    input wire logic              eye_pattern_test_en_o,
    input wire logic              low_speed_only_device_o,
    input wire logic              module_halted_o,
    input wire logic              module_suspended_o,
    input wire logic              usb_clk_en_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_rd_idle; !$past(rd_i) |-> rdata_o == 32'h0; endproperty
    property p_rd_high; $past(rd_i) |-> rdata_o[31:8] == 24'h0; endproperty
    property p_base1; $past(rd_i) && $past(addr_i) == IDX_BASE1 |-> !rdata_o[0]; endproperty
    property p_align; table_base_o[8:0] == BASE_ALIGN_Z; endproperty
    property p_eye;
        wr_i && addr_i == IDX_CFG |-> ##2 eye_pattern_test_en_o == $past(wdata_i[CFG_EYE], 2);
    endproperty
    property p_ls;
        wr_i && addr_i == IDX_CFG |-> ##2 low_speed_only_device_o == $past(wdata_i[CFG_LS_ONLY], 2);
    endproperty
    property p_halt; module_halted_o |-> !token_go_o; endproperty
    property p_susp; module_suspended_o |-> !token_go_o; endproperty
    property p_clk; $rose(module_suspended_o) |-> ##[0:1] !usb_clk_en_o; endproperty
    property p_go; token_go_o |-> $past(token_req_i); endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
    a_rd_high: assert property (p_rd_high) else $error("upper read data bits not zero");
    a_base1: assert property (p_base1) else $error("base low bit zero reads one");
    a_align: assert property (p_align) else $error("table base not aligned");
    a_eye: assert property (p_eye) else $error("eye test enable wrong");
    a_ls: assert property (p_ls) else $error("low speed enable wrong");
    a_halt: assert property (p_halt) else $error("token started while halted");
    a_susp: assert property (p_susp) else $error("token started while suspended");
    a_clk: assert property (p_clk) else $error("clock runs while suspended");
    a_go: assert property (p_go) else $error("token started without request");
    c_cfg: cover property (wr_i && addr_i == IDX_CFG);
    c_go: cover property (token_go_o);
    c_susp: cover property (module_suspended_o);
endmodule
bind usbc_cfg_regs usbc_cfg_regs_monitor u_usbc_cfg_regs_monitor (.*);
`default_nettype wire

// [test/usbc_link_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module usbc_link_partner (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic send_i,
    output logic     line_drive_o
);
    logic [3:0] left_ff;
    // Each packet holds the line driven for eight cycles, then releases it.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            left_ff <= 4'h0;
        end else if (send_i) begin
            left_ff <= 4'h8;
        end else if (left_ff != 4'h0) begin
            left_ff <= left_ff - 4'h1;
        end
    end
    assign line_drive_o = (left_ff != 4'h0);
endmodule
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin n_mismatch++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module tb
    import usbc_pkg::*;
;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} usbc_row_t;
    logic              sys_clk_i = 1'b0;
    logic              rst_b_i = 1'b0;
    logic [ADDR_W-1:0] addr_i = 8'h00;
    logic [31:0]       wdata_i = 32'h0;
    logic              wr_i = 1'b0, rd_i = 1'b0, idle_mode_i = 1'b0, sleep_mode_i = 1'b0;
    logic              host_mode_i = 1'b0, token_req_i = 1'b0, send = 1'b0;
    logic              line_drive_i, token_go_o, token_hold_o, eye_pattern_test_en_o;
    logic              output_enable_monitor_o, low_speed_only_device_o, module_halted_o;
    logic              module_suspended_o, usb_clk_en_o;
    logic [31:0]       rdata_o, table_base_o, got;
    int                n_mismatch = 0, tests_run = 0, hits;
    usbc_row_t         rows [7] = '{'{IDX_GUARD, 32'hffffff4a, 32'h4a}, '{IDX_GUARD, 32'h2a, 32'h2a},
        '{IDX_BASE1, 32'h1ff, 32'hfe}, '{IDX_BASE2, 32'ha5a5, 32'ha5}, '{IDX_BASE3, 32'hdeadbe3c, 32'h3c},
        '{IDX_CFG, 32'hffffffff, 32'hd9}, '{8'h20, 32'hffffffff, 32'h0}};
    usbc_cfg_regs #(.FRAME_CYCLES(400)) u_usbc_cfg_regs (.*);
    usbc_link_partner u_usbc_link_partner (.sys_clk_i, .rst_b_i, .send_i(send), .line_drive_o(line_drive_i));
    always #12.5 sys_clk_i = ~sys_clk_i;
    // ---------------------------------------------------------------
    // Bus tasks.
    // ---------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        @(negedge sys_clk_i);
        got = rdata_o;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task automatic count_go();
        hits = 0;
        repeat (60) begin
            @(negedge sys_clk_i);
            if (token_go_o === 1'b1) hits++;
        end
    endtask
    task automatic report_and_stop();
        if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #(25ns * 20000);
        n_mismatch++;
        report_and_stop();
    end
    // ---------------------------------------------------------------
    // Main sequence.
    // ---------------------------------------------------------------
    initial begin
        repeat (12) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        cyc(2);
        `CHK("clk_en", 1'b1, usb_clk_en_o)
        for (int k = 0; k < 8; k++) begin
            rd(k[7:0]);
            `CHK("reset", 32'h0, got)
        end
        for (int k = 0; k < 7; k++) begin
            wr(rows[k].a, rows[k].d);
            rd(rows[k].a);
            `CHK("row", rows[k].e, got)
        end
        `CHK("base", 32'h3ca5fe00, table_base_o)
        `CHK("eye", 1'b1, eye_pattern_test_en_o)
        `CHK("ls", 1'b1, low_speed_only_device_o)
        @(posedge sys_clk_i) send <= 1'b1;
        @(posedge sys_clk_i) send <= 1'b0;
        cyc(5);
        `CHK("oe_on", 1'b1, output_enable_monitor_o)
        cyc(10);
        `CHK("oe_end", 1'b0, output_enable_monitor_o)
        wr(IDX_CFG, 32'h10);
        idle_mode_i <= 1'b1;
        @(posedge sys_clk_i) send <= 1'b1;
        @(posedge sys_clk_i) send <= 1'b0;
        cyc(5);
        `CHK("oe_off", 1'b0, output_enable_monitor_o)
        `CHK("eye_off", 1'b0, eye_pattern_test_en_o)
        `CHK("halt", 1'b1, module_halted_o)
        rd(IDX_STATUS);
        `CHK("status", 32'h0000000c, got)
        wr(IDX_CFG, 32'h01);
        sleep_mode_i <= 1'b1;
        cyc(6);
        `CHK("run_idle", 1'b0, module_halted_o)
        `CHK("auto_susp", 1'b1, module_suspended_o)
        `CHK("clk_stop", 1'b0, usb_clk_en_o)
        wr(IDX_CFG, 32'h00);
        cyc(4);
        `CHK("no_auto", 1'b0, module_suspended_o)
        wr(IDX_PWR, 32'h2);
        cyc(4);
        `CHK("manual", 1'b1, module_suspended_o)
        wr(IDX_PWR, 32'h0);
        host_mode_i <= 1'b1;
        wr(IDX_GUARD, 32'hff);
        cyc(3);
        @(posedge sys_clk_i) token_req_i <= 1'b1;
        count_go();
        `CHK("guard_hold", 0, hits)
        `CHK("hold", 1'b1, token_hold_o)
        wr(IDX_GUARD, 32'h00);
        count_go();
        `CHK("guard_open", 1'b1, hits > 0)
        @(posedge sys_clk_i) host_mode_i <= 1'b0;
        wr(IDX_GUARD, 32'hff);
        count_go();
        `CHK("device_go", 1'b1, hits > 0)
        `CHK("no_hold", 1'b0, token_hold_o)
        @(posedge sys_clk_i) rst_b_i <= 1'b0;
        cyc(2);
        @(posedge sys_clk_i) rst_b_i <= 1'b1;
        rd(IDX_GUARD);
        `CHK("rereset", 32'h0, got)
        rd(IDX_LIMIT);
        `CHK("limit", 32'h0, got)
        report_and_stop();
    end
endmodule
`default_nettype wire
